// >>> common/wdtc_regs.svh
// Register offsets, field positions, reset values and counts
`ifndef WDTC_REGS_SVH
`define WDTC_REGS_SVH

`define WDTC_CTRL_OFS 32'h0000_0000
`define WDTC_STAT_OFS 32'h0000_0004

`define WDTC_UNLOCK_BIT 4
`define WDTC_RUN_BIT 3
`define WDTC_SEL_MSB 2
`define WDTC_SEL_LSB 0
`define WDTC_STAT_LVL_MSB 1
`define WDTC_STAT_LVL_LSB 0
`define WDTC_STAT_WIN_BIT 2
`define WDTC_STAT_RUN_BIT 3

`define WDTC_SEL_RST 3'h0
`define WDTC_WINDOW_CYC 3'h4
`define WDTC_BOOT_CYC 2'h3
`define WDTC_BASE_TICKS 32'h0000_4000

`define WDTC_RESP_OKAY 2'h0
`define WDTC_RESP_SLVERR 2'h2

`endif

// >>> common/wdtc_pkg.sv
// Types shared by the watchdog control modules
package wdtc_pkg;

  typedef enum logic [1:0] {
    WDTC_WIN_SHUT = 2'b01,
    WDTC_WIN_OPEN = 2'b10
  } wdtc_win_t;

  typedef enum logic [1:0] {
    WDTC_LVL0 = 2'h0,
    WDTC_LVL1 = 2'h1,
    WDTC_LVL2 = 2'h2
  } wdtc_lvl_t;

  // Safety level from the programmed state of the two fuses
  function automatic wdtc_lvl_t wdtc_level(input logic compat_prog,
                                           input logic always_on_prog);
    if (always_on_prog) begin
      return WDTC_LVL2;
    end
    if (compat_prog) begin
      return WDTC_LVL0;
    end
    return WDTC_LVL1;
  endfunction

endpackage

// >>> common/wdtc_cnt_if.sv
// Control and expiry signals between watchdog logic and its counter
`timescale 1ns/1ns
interface wdtc_cnt_if;
  logic run;
  logic clear;
  logic tick;
  logic [2:0] sel;
  logic expire;

  modport ctl (output run, output clear, output tick, output sel,
               input expire);
  modport cnt (input run, input clear, input tick, input sel,
               output expire);
endinterface

// >>> hdl/wdtc_counter.sv
// Watchdog expiry counter, counting oscillator ticks
`timescale 1ns/1ns
module wdtc_counter
  import wdtc_pkg::*;
#(
  parameter int CNT_W = 22,
  parameter int BASE_TICKS = 16384
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  wdtc_cnt_if.cnt cnt_bus
);

  if (CNT_W < $clog2(BASE_TICKS) + 8 || BASE_TICKS < 1) begin : g_bad
    $error("wdtc_counter: CNT_W too small for BASE_TICKS");
  end

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic expire;
  } wdtc_cnt_st_t;

  wdtc_cnt_st_t st;
  wdtc_cnt_st_t next_st;

  // Expiry count for a time-out select code
  function automatic logic [CNT_W-1:0] limit(input logic [2:0] sel);
    return CNT_W'(BASE_TICKS) << sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.expire = 1'b0;
    if (cnt_bus.clear || !cnt_bus.run) begin
      next_st.count = '0;
    end else if (cnt_bus.tick) begin
      if (st.count == limit(cnt_bus.sel) - CNT_W'(1)) begin
        next_st.count = '0;
        next_st.expire = 1'b1;
      end else begin
        next_st.count = st.count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cnt_bus.expire = st.expire;

endmodule // wdtc_counter

// >>> hdl/wdtc_axil_slave.sv
// AXI4-Lite slave front end for the watchdog registers
`timescale 1ns/1ns
`include "wdtc_regs.svh"
module wdtc_axil_slave
  import wdtc_pkg::*;
#(
  parameter int AW = 4
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [AW-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [AW-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_wr_en,
  output logic [AW-1:0] o_wr_addr,
  output logic [31:0] o_wr_data,
  output logic [3:0] o_wr_strb,
  input wire logic i_wr_ok,
  output logic [AW-1:0] o_rd_addr,
  input wire logic [31:0] i_rd_data,
  input wire logic i_rd_ok
);

  if (AW < 3 || AW > 32) begin : g_bad
    $error("wdtc_axil_slave: AW must be 3 to 32");
  end

  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic [AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [AW-1:0] araddr;
    logic bvalid;
    logic [1:0] bresp;
    logic rd_pend;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wdtc_axi_st_t;

  wdtc_axi_st_t st;
  wdtc_axi_st_t next_st;
  logic wr_go;

  assign wr_go = !st.aw_rdy && !st.w_rdy && !st.bvalid;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    if (i_awvalid && st.aw_rdy) begin
      next_st.aw_rdy = 1'b0;
      next_st.awaddr = i_awaddr;
    end
    if (i_wvalid && st.w_rdy) begin
      next_st.w_rdy = 1'b0;
      next_st.wdata = i_wdata;
      next_st.wstrb = i_wstrb;
    end
    if (wr_go) begin
      next_st.bvalid = 1'b1;
      next_st.bresp = i_wr_ok ? `WDTC_RESP_OKAY : `WDTC_RESP_SLVERR;
    end
    if (st.bvalid && i_bready) begin
      next_st.bvalid = 1'b0;
      next_st.aw_rdy = 1'b1;
      next_st.w_rdy = 1'b1;
    end
    if (i_arvalid && st.ar_rdy) begin
      next_st.ar_rdy = 1'b0;
      next_st.araddr = i_araddr;
      next_st.rd_pend = 1'b1;
    end
    if (st.rd_pend) begin
      next_st.rd_pend = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = i_rd_ok ? i_rd_data : 32'h0000_0000;
      next_st.rresp = i_rd_ok ? `WDTC_RESP_OKAY : `WDTC_RESP_SLVERR;
    end
    if (st.rvalid && i_rready) begin
      next_st.rvalid = 1'b0;
      next_st.ar_rdy = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '0;
      st.aw_rdy <= 1'b1;
      st.w_rdy <= 1'b1;
      st.ar_rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_awready = st.aw_rdy;
  assign o_wready = st.w_rdy;
  assign o_bvalid = st.bvalid;
  assign o_bresp = st.bresp;
  assign o_arready = st.ar_rdy;
  assign o_rvalid = st.rvalid;
  assign o_rdata = st.rdata;
  assign o_rresp = st.rresp;
  assign o_wr_en = wr_go;
  assign o_wr_addr = st.awaddr;
  assign o_wr_data = st.wdata;
  assign o_wr_strb = st.wstrb;
  assign o_rd_addr = st.araddr;

endmodule // wdtc_axil_slave

// >>> hdl/wdtc_top.sv
// Watchdog control with timed change sequences and safety levels
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "wdtc_regs.svh"

// What this block does
// - Writing run bit one starts watchdog; zero stops it where protection allows.
// - Clearing the run bit is ignored unless the unlock bit is set now.
// - A run-zero write within four cycles of opening disables the watchdog.
// - At safety level 2 the watchdog is never disabled.
// - Select code sets expiry: 16K oscillator ticks doubling per code.
// - Level 0: starts off, free enable and select, timed disable.
// - Level 1: starts off, free enable, timed select change and disable.
// - Level 1 second write within four cycles applies run and select.
// - Level 2 runs always; run bit reads back as one.
// - Level 2 second write applies select, ignores run bit.
// - Hardware clears the unlock bit four cycles after it is written.
// - Two fuses choose safety level 1, 2, 0 or 2.
// - Top three control bits read as zero.
// - Expiry issues a one-cycle reset pulse.
module wdtc_top
  import wdtc_pkg::*;
#(
  parameter int AW = 4,
  parameter int CNT_W = 22,
  parameter int BASE_TICKS = `WDTC_BASE_TICKS
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [AW-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [AW-1:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  input wire logic i_wdog_osc,
  input wire logic i_legacy_compat_fuse,
  input wire logic i_always_on_fuse,
  input wire logic i_watchdog_restart_instruction,
  output logic o_wdog_reset,
  output logic o_wdog_running
);

  if (AW < 3 || AW > 32) begin : g_bad_aw
    $error("wdtc_top: AW must be 3 to 32");
  end

  if (CNT_W < 8 || BASE_TICKS < 1) begin : g_bad_cnt
    $error("wdtc_top: counter parameters out of range");
  end

  typedef struct packed {
    logic cf_s1;
    logic cf_s2;
    logic ao_s1;
    logic ao_s2;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic [1:0] boot;
    logic lvl_ok;
    wdtc_lvl_t lvl;
    logic run;
    logic [2:0] sel;
    wdtc_win_t win;
    logic [2:0] win_cnt;
    logic clear;
    logic tick;
    logic rst_pulse;
  } wdtc_top_st_t;

  wdtc_top_st_t st;
  wdtc_top_st_t next_st;

  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic ctrl_wr;
  logic w_unlock;
  logic w_run;
  logic [2:0] w_sel;
  logic win_open;
  logic run_fixed;
  logic sel_free;
  logic stop_ok;
  logic sel_ok;

  wdtc_cnt_if u_cnt_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by reads and writes
  function automatic logic hit(input logic [AW-1:0] addr,
                               input logic [31:0] ofs);
    return {{(32 - AW){1'b0}}, addr} == ofs;
  endfunction

  // Change window state decode
  function automatic logic is_open(input wdtc_win_t w);
    return w == WDTC_WIN_OPEN;
  endfunction

  // Control register image
  function automatic logic [31:0] ctrl_image(input wdtc_top_st_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[`WDTC_UNLOCK_BIT] = is_open(s.win);
    v[`WDTC_RUN_BIT] = s.run || (s.lvl_ok && s.lvl == WDTC_LVL2);
    v[`WDTC_SEL_MSB:`WDTC_SEL_LSB] = s.sel;
    return v;
  endfunction

  // Status register image: level, window and run state
  function automatic logic [31:0] stat_image(input wdtc_top_st_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[`WDTC_STAT_LVL_MSB:`WDTC_STAT_LVL_LSB] = s.lvl;
    v[`WDTC_STAT_WIN_BIT] = is_open(s.win);
    v[`WDTC_STAT_RUN_BIT] = s.run;
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  wdtc_axil_slave #(
    .AW(AW)
  ) u_axil (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_awvalid(i_s_axi_awvalid),
    .o_awready(o_s_axi_awready),
    .i_awaddr(i_s_axi_awaddr),
    .i_wvalid(i_s_axi_wvalid),
    .o_wready(o_s_axi_wready),
    .i_wdata(i_s_axi_wdata),
    .i_wstrb(i_s_axi_wstrb),
    .o_bvalid(o_s_axi_bvalid),
    .i_bready(i_s_axi_bready),
    .o_bresp(o_s_axi_bresp),
    .i_arvalid(i_s_axi_arvalid),
    .o_arready(o_s_axi_arready),
    .i_araddr(i_s_axi_araddr),
    .o_rvalid(o_s_axi_rvalid),
    .i_rready(i_s_axi_rready),
    .o_rdata(o_s_axi_rdata),
    .o_rresp(o_s_axi_rresp),
    .o_wr_en(wr_en),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_wr_strb(wr_strb),
    .i_wr_ok(wr_ok),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data),
    .i_rd_ok(rd_ok)
  );

  wdtc_counter #(
    .CNT_W(CNT_W),
    .BASE_TICKS(BASE_TICKS)
  ) u_counter (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .cnt_bus(u_cnt_bus.cnt)
  );

  // Interface to the expiry counter
  assign u_cnt_bus.run = st.run;
  assign u_cnt_bus.clear = st.clear;
  assign u_cnt_bus.tick = st.tick;
  assign u_cnt_bus.sel = st.sel;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  assign wr_ok = hit(wr_addr, `WDTC_CTRL_OFS) || hit(wr_addr, `WDTC_STAT_OFS);
  assign rd_ok = hit(rd_addr, `WDTC_CTRL_OFS) || hit(rd_addr, `WDTC_STAT_OFS);
  assign rd_data = hit(rd_addr, `WDTC_CTRL_OFS) ? ctrl_image(st) :
                   stat_image(st);
  assign ctrl_wr = wr_en && wr_strb[0] && st.lvl_ok &&
                   hit(wr_addr, `WDTC_CTRL_OFS);
  assign w_unlock = wr_data[`WDTC_UNLOCK_BIT];
  assign w_run = wr_data[`WDTC_RUN_BIT];
  assign w_sel = wr_data[`WDTC_SEL_MSB:`WDTC_SEL_LSB];
  assign win_open = is_open(st.win);

  // Protection decode from the captured safety level
  assign run_fixed = st.lvl_ok && (st.lvl == WDTC_LVL2);
  assign sel_free = (st.lvl == WDTC_LVL0);
  assign stop_ok = win_open && !run_fixed;
  assign sel_ok = sel_free || (win_open && !w_unlock);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.clear = 1'b0;
    next_st.rst_pulse = 1'b0;

    // Fuse synchronisers, two flops before any logic
    next_st.cf_s1 = i_legacy_compat_fuse;
    next_st.cf_s2 = st.cf_s1;
    next_st.ao_s1 = i_always_on_fuse;
    next_st.ao_s2 = st.ao_s1;
    // Oscillator synchroniser; the third flop finds the rising edge
    next_st.osc_s1 = i_wdog_osc;
    next_st.osc_s2 = st.osc_s1;
    next_st.osc_s3 = st.osc_s2;
    next_st.tick = st.osc_s2 && !st.osc_s3;

    // Fuse capture once the synchronisers are filled
    if (!st.lvl_ok) begin
      if (st.boot == `WDTC_BOOT_CYC) begin
        next_st.lvl_ok = 1'b1;
        next_st.lvl = wdtc_level(st.cf_s2, st.ao_s2);
        if (wdtc_level(st.cf_s2, st.ao_s2) == WDTC_LVL2) begin
          next_st.run = 1'b1;
        end
      end else begin
        next_st.boot = st.boot + 2'h1;
      end
    end

    // Change window runs out four cycles after opening
    case (st.win)
      WDTC_WIN_OPEN: begin
        if (st.win_cnt == 3'h1) begin
          next_st.win = WDTC_WIN_SHUT;
        end else begin
          next_st.win_cnt = st.win_cnt - 3'h1;
        end
      end
      WDTC_WIN_SHUT: begin
        next_st.win_cnt = 3'h0;
      end
      default: begin
        next_st.win = WDTC_WIN_SHUT;
        next_st.win_cnt = 3'h0;
      end
    endcase

    // Software writes to the control register
    if (ctrl_wr) begin
      if (w_unlock) begin
        next_st.win = WDTC_WIN_OPEN;
        next_st.win_cnt = `WDTC_WINDOW_CYC;
      end else if (win_open) begin
        next_st.win = WDTC_WIN_SHUT;
        next_st.win_cnt = 3'h0;
      end
      if (!run_fixed) begin
        if (w_run) begin
          next_st.run = 1'b1;
        end else if (stop_ok) begin
          next_st.run = 1'b0;
        end
      end
      if (sel_ok) begin
        next_st.sel = w_sel;
      end
    end

    // Counter restart on enable, disable and restart instruction
    if (next_st.run != st.run || i_watchdog_restart_instruction) begin
      next_st.clear = 1'b1;
    end

    // Expiry while running gives a one-cycle reset request
    if (u_cnt_bus.expire && st.run) begin
      next_st.rst_pulse = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '0;
      st.lvl <= WDTC_LVL1;
      st.sel <= `WDTC_SEL_RST;
      st.win <= WDTC_WIN_SHUT;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign o_wdog_reset = st.rst_pulse;
  assign o_wdog_running = st.run;

endmodule // wdtc_top

// >>> tb/wdtc_top_chk.sv
// Checker of watchdog control port behaviour
`timescale 1ns/1ns
module wdtc_top_chk #(
  parameter int AW = 4
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [AW-1:0] i_s_axi_araddr,
  input wire logic o_s_axi_rvalid,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_rresp,
  input wire logic i_always_on_fuse,
  input wire logic o_wdog_reset,
  input wire logic o_wdog_running
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  logic [2:0] boot;
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      boot <= 3'h0;
    end else if (boot != 3'h7) begin
      boot <= boot + 3'h1;
    end
  end
  ////////////////////////////////////////
  sequence wr_take;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence rd_take;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  wr_resp_a: assert property (wr_take |-> ##1 !o_s_axi_awready ##1
    o_s_axi_bvalid) else $error("write response out of time");
  rd_resp_a: assert property (rd_take |-> ##1 !o_s_axi_arready ##1
    o_s_axi_rvalid) else $error("read response out of time");
  rd_err_a: assert property (rd_take ##0 (i_s_axi_araddr[AW-1:3] != 0)
    |-> ##2 o_s_axi_rvalid && o_s_axi_rresp == 2'h2 && o_s_axi_rdata == 0)
    else $error("unmapped read not refused");
  run_rise_a: assert property ($rose(o_wdog_running) && !i_always_on_fuse
    |-> $rose(o_s_axi_bvalid)) else $error("run rose without write");
  run_fall_a: assert property ($fell(o_wdog_running) |->
    $rose(o_s_axi_bvalid) && !i_always_on_fuse) else $error("bad stop");
  lvl2_run_a: assert property (boot == 3'h7 && i_always_on_fuse |->
    o_wdog_running) else $error("level 2 not running");
  rsvd_zero_a: assert property (o_s_axi_rvalid |->
    o_s_axi_rdata[31:5] == 27'h0) else $error("upper read bits set");
  rst_pulse_a: assert property ($rose(o_wdog_reset) |=>
    !o_wdog_reset) else $error("reset pulse too long");
  exp_run_a: assert property (o_wdog_reset |-> o_wdog_running)
    else $error("expiry while stopped");
endmodule // wdtc_top_chk

bind wdtc_top wdtc_top_chk #(.AW(AW)) u_chk (.i_core_clk, .i_arst_n,
  .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready,
  .o_s_axi_bvalid, .i_s_axi_arvalid, .o_s_axi_arready, .i_s_axi_araddr,
  .o_s_axi_rvalid, .o_s_axi_rdata, .o_s_axi_rresp, .i_always_on_fuse,
  .o_wdog_reset, .o_wdog_running);

// >>> tb/tb_wdtc_top.sv
// Self-checking testbench of the watchdog control block
`timescale 1ns/1ns
module tb_wdtc_top;
  import wdtc_pkg::*;
  localparam int AW = 4;
  localparam int BT = 16;
  logic i_core_clk, i_arst_n, i_wdog_osc, i_watchdog_restart_instruction;
  logic i_legacy_compat_fuse, i_always_on_fuse;
  logic i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
  logic i_s_axi_arvalid, i_s_axi_rready;
  logic [AW-1:0] i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rdat;
  logic [3:0] i_s_axi_wstrb;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic o_s_axi_rvalid, o_wdog_reset, o_wdog_running;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, bres, rres;
  logic [2:0] s;
  int n_mismatch, checked, seed, tk, cyc;
  wdtc_top #(.AW(AW), .CNT_W(12), .BASE_TICKS(BT)) dut (.i_core_clk,
    .i_arst_n, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_awaddr,
    .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata, .i_s_axi_wstrb,
    .o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid,
    .o_s_axi_arready, .i_s_axi_araddr, .o_s_axi_rvalid, .i_s_axi_rready,
    .o_s_axi_rdata, .o_s_axi_rresp, .i_wdog_osc, .i_legacy_compat_fuse,
    .i_always_on_fuse, .i_watchdog_restart_instruction, .o_wdog_reset,
    .o_wdog_running);
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  initial begin
    i_wdog_osc = 1'b0;
    forever #53 i_wdog_osc = ~i_wdog_osc;
  end
  always @(posedge i_wdog_osc) tk <= tk + 1;
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  ////////////////////////////////////////
  function automatic int exp_ticks(input logic [2:0] sel);
    return BT << sel;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, s);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic boot(input logic c, input logic a);
    i_arst_n <= 1'b0;
    i_legacy_compat_fuse <= c;
    i_always_on_fuse <= a;
    repeat (5) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    repeat (5) @(posedge i_core_clk);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
    logic ad, wd;
    logic [31:0] rv;
    ad = 1'b0;
    wd = 1'b0;
    rv = $random(seed);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= {rv[23:0], d};
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge i_core_clk);
      if (!ad && o_s_axi_awready) begin
        ad = 1'b1;
        i_s_axi_awvalid <= 1'b0;
      end
      if (!wd && o_s_axi_wready) begin
        wd = 1'b1;
        i_s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge i_core_clk); while (!o_s_axi_bvalid);
    bres = o_s_axi_bresp;
  endtask
  task automatic rd(input logic [AW-1:0] a);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    do @(posedge i_core_clk); while (!o_s_axi_arready);
    i_s_axi_arvalid <= 1'b0;
    do @(posedge i_core_clk); while (!o_s_axi_rvalid);
    rdat = o_s_axi_rdata;
    rres = o_s_axi_rresp;
  endtask
  task automatic expire(input logic [2:0] sel);
    int t0, d;
    i_watchdog_restart_instruction <= 1'b1;
    @(posedge i_core_clk);
    i_watchdog_restart_instruction <= 1'b0;
    t0 = tk;
    while (!o_wdog_reset) @(posedge i_core_clk);
    d = tk - t0 - exp_ticks(sel);
    chk("expiry_ok", 1, d >= -1 && d <= 1);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    {i_arst_n, i_legacy_compat_fuse, i_always_on_fuse} = 3'h0;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_arvalid} = 3'h0;
    {i_s_axi_bready, i_s_axi_rready, i_watchdog_restart_instruction} = 3'h6;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = '0;
    i_s_axi_wstrb = 4'hf;
    {seed, tk, cyc, n_mismatch, checked} = {32'h1, 128'h0};
    @(posedge i_core_clk);
    boot(1'b0, 1'b0);
    chk("run", 0, o_wdog_running);
    rd(4'h4);
    chk("level", 1, rdat[1:0]);
    rd(4'h0);
    chk("ctl", 0, rdat);
    wr(4'h0, 8'he8);
    chk("run", 1, o_wdog_running);
    wr(4'h0, 8'h0a);
    wr(4'h0, 8'h00);
    rd(4'h0);
    chk("ctl", 8'h08, rdat);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h0d);
    rd(4'h0);
    chk("ctl", 8'h0d, rdat);
    wr(4'h0, 8'h18);
    rd(4'h0);
    chk("ctl", 8'h1d, rdat);
    repeat (8) @(posedge i_core_clk);
    wr(4'h0, 8'h00);
    chk("run", 1, o_wdog_running);
    rd(4'h0);
    chk("ctl", 8'h0d, rdat);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h00);
    chk("run", 0, o_wdog_running);
    boot(1'b1, 1'b0);
    chk("run", 0, o_wdog_running);
    rd(4'h4);
    chk("level", 0, rdat[1:0]);
    for (int i = 0; i < 4; i++) begin
      s = (i == 0) ? 3'h0 : 3'($random(seed) & 3);
      wr(4'h0, {5'h1, s});
      rd(4'h0);
      chk("ctl", {5'h1, s}, rdat);
      expire(s);
    end
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h00);
    chk("run", 0, o_wdog_running);
    i_s_axi_wstrb <= 4'he;
    wr(4'h0, 8'h08);
    chk("run", 0, o_wdog_running);
    i_s_axi_wstrb <= 4'hf;
    wr(4'h8, 8'h08);
    chk("bresp", 2'h2, bres);
    chk("run", 0, o_wdog_running);
    rd(4'h8);
    chk("rresp", 2'h2, rres);
    boot(1'b0, 1'b1);
    chk("run", 1, o_wdog_running);
    rd(4'h0);
    chk("ctl", 8'h08, rdat);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h02);
    chk("run", 1, o_wdog_running);
    wr(4'h0, 8'h01);
    rd(4'h0);
    chk("ctl", 8'h0a, rdat);
    boot(1'b1, 1'b1);
    rd(4'h4);
    chk("level", 2, rdat[1:0]);
    end_sim();
  end
endmodule // tb_wdtc_top
